// ===== rtl/vector_stack_bank_map.sv
// vector selection, program counter load, stack pointer and bank decode
`timescale 1ns/1ns
`include "vector_stack_bank_map_defs.svh"
module vector_stack_bank_map (
   input wire logic CLK,
   input wire logic RST_B,
   // interrupt requests, bit 0 supply, 1..8 digital, 9..12 analog, 13 pin, 14 sleep
   input wire logic [14:0] IRQ_REQ,
   input wire logic IRQ_ENABLE,
   input wire logic PC_LOAD,
   input wire logic [13:0] PC_LOAD_VALUE,
   input wire logic PC_ADVANCE,
   input wire logic [1:0] PC_ADVANCE_BYTES,
   input wire logic STACK_PUSH,
   input wire logic STACK_POP,
   input wire logic BANK_SELECT_BIT,
   input wire logic REG_ACCESS,
   input wire logic [7:0] REG_ADDR,
   output logic [13:0] PC,
   output logic IRQ_ACK,
   output logic [3:0] IRQ_SOURCE,
   output logic [7:0] STACK_PTR,
   output logic [7:0] STACK_ADDR,
   output logic REG_SEL_BANK0,
   output logic REG_SEL_BANK1,
   output logic REG_SEL_SHARED,
   output logic [7:0] REG_SEL_ADDR,
   output logic IN_USER_SPACE
);
   // -------------------------------------------------------------
   // vector table
   // -------------------------------------------------------------
   logic [13:0] vec_table [0:`NUM_SRC];
   logic [3:0] win_idx;
   logic win_any;
   assign vec_table[0] = `VEC_SUPPLY; // [RULE_01]
   genvar gi;
   generate
      for (gi = 0; gi < `NUM_DIGITAL; gi = gi + 1) begin : g_dig
         assign vec_table[gi+1] = 14'(`VEC_DIGITAL_BASE + gi * `VEC_STEP); // [RULE_02]
      end
      for (gi = 0; gi < `NUM_ANALOG; gi = gi + 1) begin : g_ana
         assign vec_table[gi+9] = 14'(`VEC_ANALOG_BASE + gi * `VEC_STEP); // [RULE_03]
      end
   endgenerate
   assign vec_table[13] = `VEC_PIN; // [RULE_04]
   assign vec_table[14] = `VEC_SLEEP; // [RULE_04]

   // lowest index wins; supply monitor has top priority
   always_comb begin
      win_idx = 4'h0;
      win_any = 1'b0;
      for (int i = `NUM_SRC; i >= 0; i--) begin
         if (IRQ_REQ[i]) begin
            win_idx = 4'(i);
            win_any = 1'b1;
         end
      end
   end

   // -------------------------------------------------------------
   // program counter
   // -------------------------------------------------------------
   vector_stack_bank_map_pkg::pc_state_e state_ff;
   logic [13:0] nxt_pc;
   always_comb begin
      nxt_pc = PC;
      if (PC_LOAD) begin
         nxt_pc = PC_LOAD_VALUE & `PROG_TOP; // [RULE_05]
      end else if (PC_ADVANCE) begin
         nxt_pc = (PC + 14'(PC_ADVANCE_BYTES)) & `PROG_TOP; // [RULE_05]
      end
   end

   // vector load takes priority over normal flow; one ack per accepted source
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         PC <= `VEC_RESET; // [RULE_01]
         state_ff <= vector_stack_bank_map_pkg::ST_RUN;
         IRQ_ACK <= 1'b0;
         IRQ_SOURCE <= 4'h0;
      end else begin
         IRQ_ACK <= 1'b0;
         case (state_ff)
            vector_stack_bank_map_pkg::ST_RUN: begin
               if (IRQ_ENABLE && win_any) begin
                  PC <= vec_table[win_idx]; // [RULE_13]
                  IRQ_ACK <= 1'b1;
                  IRQ_SOURCE <= win_idx;
                  state_ff <= vector_stack_bank_map_pkg::ST_VECTOR;
               end else begin
                  PC <= nxt_pc;
               end
            end
            vector_stack_bank_map_pkg::ST_VECTOR: begin
               // one cycle gap so the source can drop its request
               PC <= nxt_pc;
               state_ff <= vector_stack_bank_map_pkg::ST_RUN;
            end
            default: begin
               state_ff <= vector_stack_bank_map_pkg::ST_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         IN_USER_SPACE <= 1'b0;
      end else begin
         // a vector load lands below user space, so the flag must follow it at once
         if (state_ff == vector_stack_bank_map_pkg::ST_RUN && IRQ_ENABLE && win_any) begin
            IN_USER_SPACE <= 1'b0; // [RULE_05]
         end else begin
            IN_USER_SPACE <= (nxt_pc >= `USER_START); // [RULE_05]
         end
      end
   end

   // -------------------------------------------------------------
   // hardware stack
   // -------------------------------------------------------------
   // STACK_ADDR is the byte touched: push writes at sp, pop reads at sp-1
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         STACK_PTR <= `STACK_RESET;
         STACK_ADDR <= `STACK_RESET;
      end else if (STACK_PUSH && !STACK_POP) begin
         STACK_ADDR <= STACK_PTR;
         STACK_PTR <= STACK_PTR + 8'h01; // [RULE_06] [RULE_07]
      end else if (STACK_POP && !STACK_PUSH) begin
         STACK_ADDR <= STACK_PTR - 8'h01;
         STACK_PTR <= STACK_PTR - 8'h01; // [RULE_07]
      end
   end

   // -------------------------------------------------------------
   // register bank decode
   // -------------------------------------------------------------
   logic shared_hit;
   assign shared_hit = (REG_ADDR >= `SHARED_LO) && (REG_ADDR <= `SHARED_HI);
   // reserved addresses are decoded anyway; software keeps off them [RULE_11]
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         REG_SEL_BANK0 <= 1'b0;
         REG_SEL_BANK1 <= 1'b0;
         REG_SEL_SHARED <= 1'b0;
         REG_SEL_ADDR <= 8'h00;
      end else begin
         REG_SEL_ADDR <= REG_ADDR; // [RULE_08]
         if (!REG_ACCESS) begin
            REG_SEL_BANK0 <= 1'b0;
            REG_SEL_BANK1 <= 1'b0;
            REG_SEL_SHARED <= 1'b0;
         end else if (shared_hit) begin
            REG_SEL_BANK0 <= 1'b0;
            REG_SEL_BANK1 <= 1'b0;
            REG_SEL_SHARED <= 1'b1; // [RULE_10]
         end else begin
            REG_SEL_BANK0 <= !BANK_SELECT_BIT; // [RULE_09]
            REG_SEL_BANK1 <= BANK_SELECT_BIT; // [RULE_09]
            REG_SEL_SHARED <= 1'b0;
         end
      end
   end
endmodule

// ===== rtl/vector_stack_bank_map_defs.svh
// constants for the vector table, stack and register bank map
// Functional notes
// [RULE_01] reset starts at 0x0000, supply monitor 0x0004
// [RULE_02] eight digital block vectors 0x0008 to 0x0024
// [RULE_03] four analog column vectors 0x0028 to 0x0034
// [RULE_04] pin vector 0x0038, sleep timer 0x003C
// [RULE_05] user program from 0x0040 up to 0x3FFF
// [RULE_06] stack pointer increments on each push (a push with a pop in the same cycle leaves it unchanged)
// [RULE_07] stack wraps from 0xFF to 0x00 silently
// [RULE_08] two banks of 256 register addresses
// [RULE_09] bank select flag bit steers register accesses
// [RULE_10] addresses 71h to 9fh shared by both banks
// [RULE_11] software never writes unassigned register addresses
// [RULE_12] software writes reserved bits as zero
// [RULE_13] accepted interrupt loads its vector into pc
`ifndef VECTOR_STACK_BANK_MAP_DEFS_SVH
`define VECTOR_STACK_BANK_MAP_DEFS_SVH
`define VEC_RESET 14'h0000
`define VEC_SUPPLY 14'h0004
`define VEC_DIGITAL_BASE 14'h0008
`define VEC_ANALOG_BASE 14'h0028
`define VEC_PIN 14'h0038
`define VEC_SLEEP 14'h003C
`define VEC_STEP 14'h0004
`define USER_START 14'h0040
`define PROG_TOP 14'h3FFF
`define STACK_RESET 8'h00
`define SHARED_LO 8'h71
`define SHARED_HI 8'h9F
`define NUM_DIGITAL 8
`define NUM_ANALOG 4
`define NUM_SRC 14
`endif

// ===== rtl/vector_stack_bank_map_pkg.sv
// types for the vector, stack and bank map block
package vector_stack_bank_map_pkg;
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_VECTOR = 2'b01
   } pc_state_e;
   typedef logic [13:0] prog_addr_t;
endpackage

// ===== tb/tb_vector_stack_bank_map.sv
// self-checking bench for the vector, stack and bank map
`timescale 1ns/1ns
module tb_vector_stack_bank_map;
   logic CLK = 0, RST_B = 0, IRQ_ENABLE = 0, PC_LOAD = 0, PC_ADVANCE = 0, STACK_PUSH = 0, STACK_POP = 0;
   logic BANK_SELECT_BIT = 0, REG_ACCESS = 0, IN_USER_SPACE, IRQ_ACK, REG_SEL_BANK0, REG_SEL_BANK1, REG_SEL_SHARED;
   logic [14:0] IRQ_REQ = 15'h0000;
   logic [13:0] PC_LOAD_VALUE = 14'h0000, PC;
   logic [1:0] PC_ADVANCE_BYTES = 2'h0;
   logic [7:0] REG_ADDR = 8'h00, STACK_PTR, STACK_ADDR, REG_SEL_ADDR;
   logic [3:0] IRQ_SOURCE;
   logic [7:0] adr [4] = '{8'h70, 8'h71, 8'h9F, 8'hA0};
   int fails = 0, tests_run = 0;
   always #2 CLK = ~CLK;
   vector_stack_bank_map vector_stack_bank_map_inst (.CLK, .RST_B, .IRQ_REQ, .IRQ_ENABLE, .PC_LOAD, .PC_LOAD_VALUE,
      .PC_ADVANCE, .PC_ADVANCE_BYTES, .STACK_PUSH, .STACK_POP, .BANK_SELECT_BIT, .REG_ACCESS, .REG_ADDR, .PC,
      .IRQ_ACK, .IRQ_SOURCE, .STACK_PTR, .STACK_ADDR, .REG_SEL_BANK0, .REG_SEL_BANK1, .REG_SEL_SHARED,
      .REG_SEL_ADDR, .IN_USER_SPACE);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // sleep request stays up throughout, so the lower index must win
   task automatic vectors();
      for (int i = 0; i < 15; i++) begin
         @(posedge CLK);
         IRQ_REQ <= 15'(1 << i) | 15'h4000;
         IRQ_ENABLE <= 1'b1;
         @(posedge CLK);
         IRQ_ENABLE <= 1'b0;
         #1;
         chk({2'b00, PC}, 16'(4 * (i + 1)));
         chk({11'h000, IRQ_ACK, IRQ_SOURCE}, 16'h0010 | 16'(i));
      end
      @(posedge CLK);
      IRQ_REQ <= 15'h0000;
   endtask
   // request without enable is ignored; enabled request beats a pending load
   task automatic gating();
      @(posedge CLK);
      IRQ_REQ <= 15'h0020;
      PC_LOAD_VALUE <= 14'h0100;
      PC_LOAD <= 1'b1;
      @(posedge CLK);
      IRQ_ENABLE <= 1'b1;
      #1 chk({1'b0, IRQ_ACK, PC}, 16'h0100);
      chk({15'h0000, IN_USER_SPACE}, 16'h0001);
      @(posedge CLK);
      IRQ_ENABLE <= 1'b0;
      PC_LOAD <= 1'b0;
      IRQ_REQ <= 15'h0000;
      #1 chk({1'b0, IRQ_ACK, PC}, 16'h4018);
      chk({15'h0000, IN_USER_SPACE}, 16'h0000);
   endtask
   task automatic user_space();
      @(posedge CLK);
      PC_LOAD_VALUE <= 14'h003E;
      PC_LOAD <= 1'b1;
      @(posedge CLK);
      PC_LOAD <= 1'b0;
      PC_ADVANCE <= 1'b1;
      PC_ADVANCE_BYTES <= 2'h2;
      #1 chk({15'h0000, IN_USER_SPACE}, 16'h0000);
      @(posedge CLK);
      PC_ADVANCE <= 1'b0;
      #1 chk({2'b00, PC}, 16'h0040);
      @(posedge CLK);
      #1 chk({15'h0000, IN_USER_SPACE}, 16'h0001);
   endtask
   // pointer walks the whole 256 bytes, then wraps with no fault
   task automatic stack();
      @(posedge CLK);
      STACK_PUSH <= 1'b1;
      repeat (255) @(posedge CLK);
      STACK_PUSH <= 1'b0;
      #1 chk({8'h00, STACK_PTR}, 16'h00FF);
      @(posedge CLK);
      STACK_PUSH <= 1'b1;
      @(posedge CLK);
      STACK_PUSH <= 1'b0;
      STACK_POP <= 1'b1;
      #1 chk({STACK_ADDR, STACK_PTR}, 16'hFF00);
      @(posedge CLK);
      STACK_POP <= 1'b0;
      #1 chk({8'h00, STACK_PTR}, 16'h00FF);
   endtask
   // addresses 70h, 71h, 9Fh and A0h around the shared window, decoded with each bank select value
   task automatic bank();
      for (int b = 0; b < 2; b++) begin
         for (int i = 0; i < 4; i++) begin
            @(posedge CLK);
            REG_ACCESS <= 1'b1;
            REG_ADDR <= adr[i];
            BANK_SELECT_BIT <= b[0];
            @(posedge CLK);
            REG_ACCESS <= 1'b0;
            #1 chk({13'h0000, REG_SEL_BANK1, REG_SEL_BANK0, REG_SEL_SHARED},
               (i == 1 || i == 2) ? 16'h0001 : (b == 1 ? 16'h0004 : 16'h0002));
            chk({8'h00, REG_SEL_ADDR}, {8'h00, adr[i]});
         end
      end
   endtask
   initial begin
      repeat (4) @(posedge CLK);
      RST_B <= 1'b1;
      #1 chk({2'b00, PC}, 16'h0000);
      vectors();
      user_space();
      gating();
      stack();
      bank();
      stop_test();
   end
   initial begin
      #200000;
      fails++;
      stop_test();
   end
endmodule

// ===== tb/vector_stack_bank_map_chk.sv
// concurrent checks on the vector, stack and bank map ports
`timescale 1ns/1ns
module vector_stack_bank_map_chk (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic [14:0] IRQ_REQ,
   input wire logic IRQ_ENABLE,
   input wire logic STACK_PUSH,
   input wire logic STACK_POP,
   input wire logic BANK_SELECT_BIT,
   input wire logic REG_ACCESS,
   input wire logic [7:0] REG_ADDR,
   input wire logic [13:0] PC,
   input wire logic IRQ_ACK,
   input wire logic [3:0] IRQ_SOURCE,
   input wire logic [7:0] STACK_PTR,
   input wire logic [7:0] STACK_ADDR,
   input wire logic REG_SEL_BANK0,
   input wire logic REG_SEL_BANK1,
   input wire logic REG_SEL_SHARED
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   wire logic shr = REG_ADDR >= 8'h71 && REG_ADDR <= 8'h9F;
   a_reset_start: assert property ($rose(RST_B) |-> PC == 14'h0000) else $error("pc not zero after reset");
   a_supply_vec: assert property ((IRQ_ENABLE && IRQ_REQ[0] && !IRQ_ACK) |=> IRQ_ACK && PC == 14'h0004)
      else $error("supply vector not taken");
   a_vec_map: assert property (IRQ_ACK |-> PC == {8'h00, IRQ_SOURCE + 4'h1, 2'b00})
      else $error("vector address does not match source");
   a_ack_pulse: assert property (IRQ_ACK |=> !IRQ_ACK) else $error("ack longer than one cycle");
   a_stack_push: assert property ((STACK_PUSH && !STACK_POP) |=> STACK_PTR == $past(STACK_PTR) + 8'h01
      && STACK_ADDR == $past(STACK_PTR)) else $error("push did not step pointer up");
   a_bank_shared: assert property ((REG_ACCESS && shr) |=> REG_SEL_SHARED && !REG_SEL_BANK0 && !REG_SEL_BANK1)
      else $error("shared window not decoded");
   a_bank_steer: assert property ((REG_ACCESS && !shr) |=> !REG_SEL_SHARED
      && REG_SEL_BANK1 == $past(BANK_SELECT_BIT) && REG_SEL_BANK0 != $past(BANK_SELECT_BIT))
      else $error("bank steering wrong");
   a_bank_idle: assert property (!REG_ACCESS |=> !REG_SEL_BANK0 && !REG_SEL_BANK1 && !REG_SEL_SHARED)
      else $error("select without access");
endmodule
bind vector_stack_bank_map vector_stack_bank_map_chk vector_stack_bank_map_chk_inst (.CLK, .RST_B, .IRQ_REQ,
   .IRQ_ENABLE, .STACK_PUSH, .STACK_POP, .BANK_SELECT_BIT, .REG_ACCESS, .REG_ADDR, .PC, .IRQ_ACK, .IRQ_SOURCE,
   .STACK_PTR, .STACK_ADDR, .REG_SEL_BANK0, .REG_SEL_BANK1, .REG_SEL_SHARED);
